// ===== hdl/ats_sequencer.sv
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Four-buffer single trigger: match 0 converts input, results go to slots 0..3.
// - Four-buffer single trigger: interrupt only after fourth conversion, then halt.
// - Enable cleared before four matches: no interrupt, back to standby.
// - Four-buffer four trigger: result stored in slot of the firing channel.
// - Four-trigger: after fourth conversion interrupt, active flag cleared, stop.
// - One-shot: end after four; first match after restart sets active, converts.
// - Loop timer: keep converting on every match while enable stays set.
// - Match triggers accepted in any order, repeats count as fresh triggers.
// - Single-trigger scan steps inputs upward from input zero, one per trigger.
// - Scan within inputs 0..3: interrupt and stop after the configured count.
// - Scan reaching 4..7: upper inputs converted back to back, then interrupt.
// - Inputs 4..7 are never started by a compare match.
// - Single-trigger scan: match after completion restarts scan from input zero.
// - Scan with too few matches: no interrupt, standby when enable clears.
// - Four-trigger scan: channel k converts input k into slot k.
// - Four-trigger scan restarts on first match after completion when looping.
// - Only falling edges of the external trigger pin start conversions.
// - Clearing enable mid conversion aborts it, no result is written.
module ats_sequencer #(
  parameter int RES_W = 16
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Triggers
  input wire logic [3:0] compare_match_pulse_i,
  input wire logic external_trigger_pin_i,
  // Analog core
  output logic conv_start_o,
  output logic [2:0] conv_chan_o,
  input wire logic [RES_W-1:0] conv_result_i,
  input wire logic conv_done_i,
  // Status
  output logic conversion_end_irq_o,
  output logic conversion_active_o
);
  // ==========================================================
  // State
  typedef struct packed {
    // Sequencing position
    ats_pkg::ats_state_e state;
    logic [15:0] ctrl;
    logic [2:0] count;
    logic [2:0] chan;
    logic [1:0] slot;
    // Sticky flag, active level and one-cycle outputs
    logic done_flag;
    logic start;
    logic irq;
    logic active;
    logic [15:0] rdata;
    // Result storage, one word per input
    logic [7:0][RES_W-1:0] result;
  } ats_seq_s;

  ats_seq_s st_reg;
  ats_seq_s st_next;
  logic ext_fall;

  // Lowest-numbered match wins when several coincide
  function automatic logic [1:0] ats_first_match(input logic [3:0] m);
    ats_first_match = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        ats_first_match = 2'(i);
      end
    end
  endfunction : ats_first_match

  // Halt after the last conversion: one end pulse, active dropped, done set
  function automatic ats_seq_s ats_finish(input ats_seq_s s);
    ats_finish = s;
    ats_finish.state = ats_pkg::ATS_HALT;
    ats_finish.irq = 1'b1;
    ats_finish.active = 1'b0;
    ats_finish.done_flag = 1'b1;
  endfunction : ats_finish

  // Register read mux, unmapped words read as zero
  function automatic logic [15:0] ats_read_word(input logic [3:0] a, input ats_seq_s s);
    ats_read_word = 16'h0000;
    if (a == ats_pkg::ATS_OFS_CTRL) begin
      ats_read_word = s.ctrl;
    end else if (a == ats_pkg::ATS_OFS_STATUS) begin
      ats_read_word[ats_pkg::ATS_STAT_ACTIVE_BIT] = s.active;
      ats_read_word[ats_pkg::ATS_STAT_DONE_BIT] = s.done_flag;
    end else if (a >= ats_pkg::ATS_OFS_RESULT0) begin
      ats_read_word = 16'(s.result[a[2:0]]);
    end
  endfunction : ats_read_word

  // ==========================================================
  // External trigger pin synchroniser
  ats_edge_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(external_trigger_pin_i),
    .fall_o(ext_fall)
  );

  // ==========================================================
  // Control decode
  logic enable;
  logic scan_mode;
  logic four_buf;
  logic four_trig;
  logic [2:0] sel_chan;
  logic ext_mode;
  logic trig_any;
  logic [1:0] trig_idx;

  always_comb begin
    enable = st_reg.ctrl[ats_pkg::ATS_CTRL_ENABLE_BIT];
    scan_mode = st_reg.ctrl[ats_pkg::ATS_CTRL_SCAN_BIT];
    four_buf = st_reg.ctrl[ats_pkg::ATS_CTRL_FOURBUF_BIT];
    four_trig = st_reg.ctrl[ats_pkg::ATS_CTRL_FOURTRIG_BIT];
    sel_chan = st_reg.ctrl[ats_pkg::ATS_CTRL_CHAN_LSB +: 3];
    ext_mode = st_reg.ctrl[ats_pkg::ATS_CTRL_PINFN_BIT]
               && (st_reg.ctrl[ats_pkg::ATS_CTRL_TRIG_LSB +: 3]
                   == ats_pkg::ATS_TRIG_EXTERNAL);
  end

  // ==========================================================
  // Trigger select
  // Pin edge in external mode, otherwise the match pulses
  always_comb begin
    trig_idx = 2'h0;
    trig_any = 1'b0;
    if (ext_mode) begin
      trig_any = ext_fall;
    end else if (four_trig) begin
      trig_any = |compare_match_pulse_i;
      trig_idx = ats_first_match(compare_match_pulse_i);
    end else begin
      trig_any = compare_match_pulse_i[0];
    end
  end

  // ==========================================================
  // Completion and steering decode
  logic trig_take;
  logic halt_restart;
  logic [2:0] timed_chan;
  logic [2:0] store_idx;
  logic sw_last;
  logic scan_upper;
  logic scan_last;
  logic four_last;
  logic run_last;

  // Trigger taken only while waiting or halted, a busy core ignores it
  always_comb begin
    halt_restart = (st_reg.state == ats_pkg::ATS_HALT);
    trig_take = trig_any
                && ((st_reg.state == ats_pkg::ATS_WAIT_TRIG) || halt_restart);
  end

  // Timer and pin triggers reach the lower four inputs only
  always_comb begin
    timed_chan = {1'b0, sel_chan[1:0]};
  end

  // Scan keeps one word per input, buffer modes use the slot
  always_comb begin
    store_idx = scan_mode ? st_reg.chan : {1'b0, st_reg.slot};
  end

  // Last back-to-back upper input reached
  always_comb begin
    sw_last = (st_reg.chan == sel_chan);
  end

  // End of the timed part of a run, or hand-over to the upper inputs
  always_comb begin
    scan_upper = scan_mode && (st_reg.count == ats_pkg::ATS_LOWER_LAST)
                 && (sel_chan > ats_pkg::ATS_LOWER_LAST);
    scan_last = scan_mode && (st_reg.count >= sel_chan);
    four_last = four_buf
                && (st_reg.count == ats_pkg::ATS_FOUR_COUNT_LAST);
    run_last = scan_last || (!scan_mode && !four_buf) || four_last;
  end

  // ==========================================================
  // Sequencer next state
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.irq = 1'b0;
    st_next.rdata = 16'h0000;
    // Register reads, data one cycle later
    if (rd_i) begin
      st_next.rdata = ats_read_word(addr_i, st_reg);
    end
    // Control and status writes win over a conversion finishing in the same cycle
    if (wr_i && addr_i == ats_pkg::ATS_OFS_CTRL) begin
      st_next.ctrl = wdata_i;
      if (!wdata_i[ats_pkg::ATS_CTRL_ENABLE_BIT]) begin
        st_next.state = ats_pkg::ATS_IDLE;
        st_next.active = 1'b0;
      end else if (!enable) begin
        st_next.state = ats_pkg::ATS_WAIT_TRIG;
        st_next.count = 3'h0;
        st_next.chan = 3'h0;
      end
    end else if (wr_i && addr_i == ats_pkg::ATS_OFS_STATUS) begin
      st_next.done_flag = st_reg.done_flag & ~wdata_i[ats_pkg::ATS_STAT_DONE_BIT];
    end else begin
      // Sequencing, loop or one-shot restarts are the timer's choice
      case (st_reg.state)
        ats_pkg::ATS_IDLE: begin
          st_next.active = 1'b0;
        end
        ats_pkg::ATS_WAIT_TRIG, ats_pkg::ATS_HALT: begin
          if (trig_take) begin
            if (halt_restart) begin
              st_next.count = 3'h0;
            end
            st_next.start = 1'b1;
            st_next.active = 1'b1;
            st_next.state = ats_pkg::ATS_CONVERT;
            if (scan_mode) begin
              st_next.chan = four_trig ? {1'b0, trig_idx}
                             : (halt_restart ? 3'h0
                                : st_reg.count);
              st_next.slot = st_next.chan[1:0];
            end else begin
              st_next.chan = timed_chan;
              st_next.slot = four_trig ? trig_idx
                             : (halt_restart ? 2'h0
                                : st_reg.count[1:0]);
            end
          end
        end
        ats_pkg::ATS_CONVERT, ats_pkg::ATS_SW_CONVERT: begin
          if (conv_done_i) begin
            st_next.result[store_idx] = conv_result_i;
            st_next.count = st_reg.count + 3'h1;
            if (st_reg.state == ats_pkg::ATS_SW_CONVERT) begin
              if (sw_last) begin
                st_next = ats_finish(st_next);
              end else begin
                st_next.chan = st_reg.chan + 3'h1;
                st_next.start = 1'b1;
              end
            end else if (scan_upper) begin
              st_next.state = ats_pkg::ATS_SW_CONVERT;
              st_next.chan = 3'h4;
              st_next.start = 1'b1;
            end else if (run_last) begin
              st_next = ats_finish(st_next);
            end else begin
              st_next.state = ats_pkg::ATS_WAIT_TRIG;
            end
          end
        end
        default: begin
          st_next.state = ats_pkg::ATS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '{
        state: ats_pkg::ATS_IDLE,
        ctrl: ats_pkg::ATS_CTRL_RESET,
        count: 3'h0,
        chan: 3'h0,
        slot: 2'h0,
        done_flag: 1'b0,
        start: 1'b0,
        irq: 1'b0,
        active: 1'b0,
        rdata: 16'h0000,
        result: '0
      };
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign rdata_o = st_reg.rdata;
  assign conv_start_o = st_reg.start;
  assign conv_chan_o = st_reg.chan;
  assign conversion_end_irq_o = st_reg.irq;
  assign conversion_active_o = st_reg.active;
endmodule : ats_sequencer
`default_nettype wire

// ===== shared/ats_pkg.sv
package ats_pkg;
  // ==========================================================
  // Register offsets (word index equals byte address / 1)
  localparam logic [3:0] ATS_OFS_CTRL = 4'h0;
  localparam logic [3:0] ATS_OFS_STATUS = 4'h1;
  localparam logic [3:0] ATS_OFS_RESULT0 = 4'h8;
  // ==========================================================
  // Control register fields
  localparam int ATS_CTRL_ENABLE_BIT = 0;
  localparam int ATS_CTRL_SCAN_BIT = 1;
  localparam int ATS_CTRL_FOURBUF_BIT = 2;
  localparam int ATS_CTRL_FOURTRIG_BIT = 3;
  localparam int ATS_CTRL_LOOP_BIT = 4;
  localparam int ATS_CTRL_CHAN_LSB = 8;
  localparam int ATS_CTRL_TRIG_LSB = 12;
  localparam int ATS_CTRL_PINFN_BIT = 15;
  // ==========================================================
  // Status register fields
  localparam int ATS_STAT_ACTIVE_BIT = 0;
  localparam int ATS_STAT_DONE_BIT = 1;
  // ==========================================================
  // Trigger source codes, reset values and input and count limits
  localparam logic [2:0] ATS_TRIG_EXTERNAL = 3'h6;
  localparam logic [15:0] ATS_CTRL_RESET = 16'h0000;
  localparam logic [2:0] ATS_LOWER_LAST = 3'h3;
  localparam logic [2:0] ATS_UPPER_LAST = 3'h7;
  localparam logic [2:0] ATS_FOUR_COUNT_LAST = 3'h3;
  localparam logic [15:0] ATS_RESULT_RESET = 16'h0000;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ATS_IDLE,
    ATS_WAIT_TRIG,
    ATS_CONVERT,
    ATS_SW_CONVERT,
    ATS_HALT
  } ats_state_e;
endpackage : ats_pkg

// ===== hdl/ats_edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Two-flop synchroniser and falling edge detector
module ats_edge_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic fall_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic fall;
  } ats_sync_s;

  ats_sync_s st_reg;
  ats_sync_s st_next;

  // Next state, edge taken only from the second flop onward
  always_comb begin
    st_next = st_reg;
    st_next.meta = pin_i;
    st_next.sync = st_reg.meta;
    st_next.last = st_reg.sync;
    st_next.fall = st_reg.last & ~st_reg.sync;
  end

  // Registers, idle-high pin
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '{meta: 1'b1, sync: 1'b1, last: 1'b1, fall: 1'b0};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign fall_o = st_reg.fall;
endmodule : ats_edge_sync
`default_nettype wire

// ===== dv/ats_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checker for the sequencer
module ats_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [3:0] compare_match_pulse_i,
  input wire logic conv_start_o,
  input wire logic [2:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic conversion_end_irq_o,
  input wire logic conversion_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Last result taken, then the end pulse
  sequence final_done;
    conv_done_i ##1 conversion_end_irq_o;
  endsequence
  // Start, irq and read data relations
  start_gap_a: assert property (conv_start_o |=> !conv_start_o [*2])
    else $error("start pulse too wide or too soon");
  irq_pulse_a: assert property (final_done |=> !conversion_end_irq_o)
    else $error("end pulse wider than one cycle");
  irq_cause_a: assert property (conversion_end_irq_o |-> $past(conv_done_i))
    else $error("end pulse without a finished conversion");
  irq_active_a: assert property (conversion_end_irq_o |-> $past(conversion_active_o))
    else $error("end pulse while in standby");
  active_clear_a: assert property (final_done |-> ##[0:1] !conversion_active_o)
    else $error("active flag kept after the end");
  upper_untimed_a: assert property (conv_start_o && $past(compare_match_pulse_i) != 4'h0
    |-> conv_chan_o <= 3'h3)
    else $error("upper input started by a match");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  start_active_a: assert property (conv_start_o |-> conversion_active_o)
    else $error("start without active flag");
endmodule : ats_monitor
bind ats_sequencer ats_monitor chk (.clk_i, .rst_i, .rd_i, .rdata_o,
  .compare_match_pulse_i, .conv_start_o, .conv_chan_o, .conv_done_i,
  .conversion_end_irq_o, .conversion_active_o);
`default_nettype wire

// ===== dv/ats_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Conversion core stand-in, fast or slow
module ats_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic start_i,
  input wire logic [15:0] value_i,
  output logic [15:0] result_o,
  output logic done_o
);
  int cnt;
  logic [15:0] held;
  // Count down from start, one-cycle done
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      held <= 16'h0000;
    end else begin
      done_o <= (cnt == 1);
      cnt <= start_i ? (slow_i ? 9 : 2) : (cnt != 0 ? cnt - 1 : 0);
      if (start_i) held <= value_i;
    end
  end
  // Result only valid with done
  assign result_o = done_o ? held : ~held;
endmodule : ats_core_model
`default_nettype wire

// ===== dv/adc_trigger_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Bench for the trigger sequencer
module adc_trigger_sequencer_bench;
  logic clk_i = 0, rst_i = 1, wr = 0, rd = 0, slow = 0, pin = 1;
  logic [3:0] addr = 0, cmp = 0;
  logic [15:0] wdata = 0, val = 0, rdata, res, d;
  logic start, done, irq, act;
  logic [2:0] chan;
  logic [31:0] lf = 32'h0808;
  logic [15:0] ex [8];
  logic [2:0] chq [$], expq [$];
  int mismatches = 0, samples_checked = 0, irqs = 0;
  localparam logic [15:0] en = 16'h0001 << ats_pkg::ATS_CTRL_ENABLE_BIT;
  localparam logic [15:0] fb = 16'h0001 << ats_pkg::ATS_CTRL_FOURBUF_BIT;
  localparam logic [15:0] ft = 16'h0001 << ats_pkg::ATS_CTRL_FOURTRIG_BIT;
  localparam logic [15:0] sc = 16'h0001 << ats_pkg::ATS_CTRL_SCAN_BIT;
  ats_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .compare_match_pulse_i(cmp), .external_trigger_pin_i(pin),
    .conv_start_o(start), .conv_chan_o(chan), .conv_result_i(res),
    .conv_done_i(done), .conversion_end_irq_o(irq), .conversion_active_o(act));
  ats_core_model core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .start_i(start),
    .value_i(val), .result_o(res), .done_o(done));
  // Clock and reset
  initial forever #10 clk_i = ~clk_i;
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
  end
  // Record end pulses and started channels
  always @(posedge clk_i) begin
    if (irq === 1'b1) irqs++;
    if (start === 1'b1) chq.push_back(chan);
  end
  function logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task chk(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, seen, want);
    end
  endtask : chk
  task wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge clk_i);
    wr <= 0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a);
    @(posedge clk_i);
    addr <= a;
    rd <= 1;
    @(posedge clk_i);
    rd <= 0;
    #1 d = rdata;
  endtask : rd_reg
  // One match pulse, then core latency plus store
  task trig(input int k, input int slot, input logic [2:0] c);
    lf = nx(lf);
    @(posedge clk_i);
    val <= lf[15:0];
    cmp <= 4'h1 << k;
    @(posedge clk_i);
    cmp <= 4'h0;
    ex[slot] = lf[15:0];
    expq.push_back(c);
    repeat (14) @(posedge clk_i);
  endtask : trig
  // One low pulse on the trigger pin, input 3 into the given slot
  task ext(input int slot);
    lf = nx(lf);
    @(posedge clk_i);
    val <= lf[15:0];
    pin <= 0;
    repeat (4) @(posedge clk_i);
    pin <= 1;
    ex[slot] = lf[15:0];
    expq.push_back(3'h3);
    repeat (14) @(posedge clk_i);
  endtask : ext
  // Compare results and started channels with the model
  task chk_all(input int n);
    for (int i = 0; i < n; i++) begin
      rd_reg(ats_pkg::ATS_OFS_RESULT0 + 4'(i));
      chk(d, ex[i]);
    end
    chk(16'(chq.size()), 16'(expq.size()));
    while (chq.size() > 0 && expq.size() > 0) chk(chq.pop_front(), expq.pop_front());
  endtask : chk_all
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    wr_reg(ats_pkg::ATS_OFS_CTRL, en | fb | 16'h0200);
    for (int i = 0; i < 4; i++) begin
      trig(0, i, 3'h2);
      chk(16'(irqs), 16'(i == 3));
    end
    chk_all(4);
    wr_reg(ats_pkg::ATS_OFS_CTRL, en | fb | ft | 16'h0100);
    trig(2, 2, 3'h1);
    trig(0, 0, 3'h1);
    trig(3, 3, 3'h1);
    trig(3, 3, 3'h1);
    chk(16'(irqs), 16'h0002);
    chk({15'h0000, act}, 16'h0000);
    trig(1, 1, 3'h1);
    chk({15'h0000, act}, 16'h0001);
    chk_all(4);
    slow <= 1;
    @(posedge clk_i);
    cmp <= 4'h1;
    expq.push_back(3'h1);
    @(posedge clk_i);
    cmp <= 4'h0;
    wr_reg(ats_pkg::ATS_OFS_CTRL, 16'h0000);
    repeat (15) @(posedge clk_i);
    chk(16'(irqs), 16'h0002);
    chk({15'h0000, act}, 16'h0000);
    chk_all(4);
    slow <= 0;
    wr_reg(ats_pkg::ATS_OFS_CTRL, en | sc | 16'h0700);
    for (int i = 0; i < 4; i++) trig(0, i, 3'(i));
    repeat (40) @(posedge clk_i);
    for (int i = 4; i < 8; i++) begin
      ex[i] = val;
      expq.push_back(3'(i));
    end
    chk(16'(irqs), 16'h0003);
    chk_all(8);
    trig(0, 0, 3'h0);
    chk_all(8);
    wr_reg(ats_pkg::ATS_OFS_CTRL, 16'h0000);
    wr_reg(ats_pkg::ATS_OFS_CTRL, en | sc | ft | 16'h0300);
    trig(2, 2, 3'h2);
    trig(0, 0, 3'h0);
    trig(3, 3, 3'h3);
    trig(1, 1, 3'h1);
    chk(16'(irqs), 16'h0004);
    trig(3, 3, 3'h3);
    chk({15'h0000, act}, 16'h0001);
    chk_all(4);
    wr_reg(ats_pkg::ATS_OFS_CTRL, 16'h0000);
    wr_reg(ats_pkg::ATS_OFS_CTRL, en | 16'hE300);
    trig(0, 1, 3'h3);
    void'(expq.pop_back());
    ex[1] = d;
    rd_reg(ats_pkg::ATS_OFS_RESULT0 + 4'h1);
    ex[1] = d;
    chk(16'(irqs), 16'h0004);
    ext(0);
    chk(16'(irqs), 16'h0005);
    ext(0);
    chk(16'(irqs), 16'h0006);
    chk_all(4);
    end_of_test();
  end
endmodule : adc_trigger_sequencer_bench
`default_nettype wire
